// ===== hdl/mbx_pkg.sv
// package of address map, master ids, transfer sizes and sub-region tags for the bus matrix decoder
package mbx_pkg;
  localparam int unsigned NUM_MST = 5;
  localparam int unsigned NUM_SLV = 16;
  localparam int unsigned MST_W = 3;
  localparam int unsigned SLV_W = 4;
  // master indices
  localparam logic [MST_W-1:0] M_ICODE = 3'h0;
  localparam logic [MST_W-1:0] M_DCODE = 3'h1;
  localparam logic [MST_W-1:0] M_SYS = 3'h2;
  localparam logic [MST_W-1:0] M_DMA = 3'h3;
  localparam logic [MST_W-1:0] M_ETH = 3'h4;
  // slave indices
  typedef enum logic [SLV_W-1:0] {
    SLV_NONE = 4'h0,
    SLV_MAIN_FLASH = 4'h1,
    SLV_CODE_RAM = 4'h2,
    SLV_SYS_RAM = 4'h3,
    SLV_WORK_FLASH = 4'h4,
    SLV_WORK_FIF = 4'h5,
    SLV_EXT_BUS = 4'h6,
    SLV_MAIN_FIF = 4'h7,
    SLV_PBUS0 = 4'h8,
    SLV_PBUS1 = 4'h9,
    SLV_PBUS2 = 4'hA,
    SLV_HS_AHB = 4'hB,
    SLV_BB_ALIAS = 4'hC,
    SLV_PPB = 4'hD
  } mbx_slv_t;
  // memory map
  localparam logic [31:0] MAIN_FLASH_BASE = 32'h0000_0000;
  localparam logic [31:0] MAIN_FLASH_SIZE = 32'h0010_0000;
  localparam logic [31:0] RAM_SPLIT = 32'h2000_0000;
  localparam logic [31:0] RAM_BANK_SIZE = 32'h0008_0000;
  localparam logic [31:0] WORK_FLASH_BASE = 32'h200C_0000;
  localparam logic [31:0] WORK_FIF_BASE = 32'h200E_0000;
  localparam logic [31:0] WORK_FIF_END = 32'h200E_0FFF;
  localparam logic [31:0] SRAM_BB_BASE = 32'h2200_0000;
  localparam logic [31:0] SRAM_BB_END = 32'h23FF_FFFF;
  localparam logic [31:0] MAIN_FIF_BASE = 32'h4000_0000;
  localparam logic [31:0] MAIN_FIF_END = 32'h4000_0FFF;
  localparam logic [31:0] PBUS0_BASE = 32'h4001_0000;
  localparam logic [31:0] PBUS0_END = 32'h4001_FFFF;
  localparam logic [31:0] PBUS1_BASE = 32'h4002_0000;
  localparam logic [31:0] PBUS1_END = 32'h4002_EFFF;
  localparam logic [31:0] PBUS2_BASE = 32'h4003_0000;
  localparam logic [31:0] PBUS2_END = 32'h4003_FFFF;
  localparam logic [31:0] LVD_BASE = 32'h4003_5000;
  localparam logic [31:0] LVD_END = 32'h4003_50FF;
  localparam logic [31:0] DSTBY_BASE = 32'h4003_5100;
  localparam logic [31:0] DSTBY_END = 32'h4003_5FFF;
  localparam logic [31:0] HS_BASE = 32'h4004_0000;
  localparam logic [31:0] HS_END = 32'h4006_8FFF;
  // reserved holes inside the decoded bus windows, then the bit-band, external and ppb windows
  localparam logic [31:0] RSV0_BASE = 32'h4001_3000;
  localparam logic [31:0] RSV0_END = 32'h4001_4FFF;
  localparam logic [31:0] RSV1_BASE = 32'h4001_6000;
  localparam logic [31:0] RSV1_END = 32'h4001_FFFF;
  localparam logic [31:0] RSV2_BASE = 32'h4002_3000;
  localparam logic [31:0] RSV2_END = 32'h4002_3FFF;
  localparam logic [31:0] RSV3_BASE = 32'h4002_9000;
  localparam logic [31:0] RSV3_END = 32'h4002_DFFF;
  localparam logic [31:0] RSV4_BASE = 32'h4003_D000;
  localparam logic [31:0] RSV4_END = 32'h4003_EFFF;
  localparam logic [31:0] RSV5_BASE = 32'h4006_1000;
  localparam logic [31:0] RSV5_END = 32'h4006_1FFF;
  localparam logic [31:0] PER_BB_BASE = 32'h4200_0000;
  localparam logic [31:0] PER_BB_END = 32'h43FF_FFFF;
  localparam logic [31:0] EXT_BASE = 32'h6000_0000;
  localparam logic [31:0] EXT_END = 32'hDFFF_FFFF;
  localparam logic [31:0] PPB_BASE = 32'hE000_0000;
  localparam logic [31:0] PPB_END = 32'hE00F_FFFF;
  // transfer sizes
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  // sub-region tags for the third peripheral page split
  localparam logic [1:0] SUB_OTHER = 2'h0;
  localparam logic [1:0] SUB_LVD = 2'h1;
  localparam logic [1:0] SUB_DSTBY = 2'h2;
endpackage : mbx_pkg

// ===== hdl/mbx_matrix.sv
// multi-layer bus matrix: decode, arbitration, rmw locking and error response
`timescale 1ns/1ps
`default_nettype none
module mbx_matrix (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // strap: high on the first product variant
  input wire logic i_first_product_variant,
  // master request side, one lane per master
  input wire logic [4:0] i_m_req,
  input wire logic [4:0] i_m_write,
  input wire logic [4:0] i_m_bitband,
  input wire logic [159:0] i_m_addr,
  input wire logic [9:0] i_m_size,
  input wire logic [159:0] i_m_wdata,
  // master answer side
  output logic [4:0] o_m_grant,
  output logic [4:0] o_m_done,
  output logic [4:0] o_m_err,
  output logic [159:0] o_m_rdata,
  // shared slave-side port for the granted access
  output logic o_s_valid,
  output logic [3:0] o_s_sel,
  output logic [1:0] o_s_sub,
  output logic [31:0] o_s_addr,
  output logic o_s_write,
  output logic [3:0] o_s_strb,
  output logic [31:0] o_s_wdata,
  output logic o_s_rmw,
  output logic o_s_lock,
  output logic [2:0] o_s_master,
  input wire logic i_s_ready,
  input wire logic [31:0] i_s_rdata,
  input wire logic [31:0] i_s_hw_flags
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACCESS = 2'b01,
    ST_RMW_WR = 2'b10,
    ST_DONE = 2'b11
  } mbx_state_t;

  // reserved holes between peripherals inside the decoded bus windows
  function automatic logic in_hole(input logic [31:0] a);
    logic h;
    h = 1'b0;
    if (a >= mbx_pkg::RSV0_BASE && a <= mbx_pkg::RSV0_END) begin
      h = 1'b1;
    end else if (a >= mbx_pkg::RSV1_BASE && a <= mbx_pkg::RSV1_END) begin
      h = 1'b1;
    end else if (a >= mbx_pkg::RSV2_BASE && a <= mbx_pkg::RSV2_END) begin
      h = 1'b1;
    end else if (a >= mbx_pkg::RSV3_BASE && a <= mbx_pkg::RSV3_END) begin
      h = 1'b1;
    end else if (a >= mbx_pkg::RSV4_BASE && a <= mbx_pkg::RSV4_END) begin
      h = 1'b1;
    end else if (a >= mbx_pkg::RSV5_BASE && a <= mbx_pkg::RSV5_END) begin
      h = 1'b1;
    end
    return h;
  endfunction : in_hole

  // address decode shared by all masters
  function automatic mbx_pkg::mbx_slv_t decode(input logic [31:0] a);
    mbx_pkg::mbx_slv_t s;
    s = mbx_pkg::SLV_NONE;
    if (a < mbx_pkg::MAIN_FLASH_BASE + mbx_pkg::MAIN_FLASH_SIZE) begin
      s = mbx_pkg::SLV_MAIN_FLASH;
    end else if (a >= mbx_pkg::RAM_SPLIT - mbx_pkg::RAM_BANK_SIZE && a < mbx_pkg::RAM_SPLIT) begin
      s = mbx_pkg::SLV_CODE_RAM;
    end else if (a >= mbx_pkg::RAM_SPLIT && a < mbx_pkg::RAM_SPLIT + mbx_pkg::RAM_BANK_SIZE) begin
      s = mbx_pkg::SLV_SYS_RAM;
    end else if (a >= mbx_pkg::WORK_FLASH_BASE && a < mbx_pkg::WORK_FIF_BASE) begin
      s = mbx_pkg::SLV_WORK_FLASH;
    end else if (a >= mbx_pkg::WORK_FIF_BASE && a <= mbx_pkg::WORK_FIF_END) begin
      s = mbx_pkg::SLV_WORK_FIF;
    end else if (a >= mbx_pkg::SRAM_BB_BASE && a <= mbx_pkg::SRAM_BB_END) begin
      s = mbx_pkg::SLV_BB_ALIAS;
    end else if (a >= mbx_pkg::MAIN_FIF_BASE && a <= mbx_pkg::MAIN_FIF_END) begin
      s = mbx_pkg::SLV_MAIN_FIF;
    end else if (a >= mbx_pkg::PBUS0_BASE && a <= mbx_pkg::PBUS0_END) begin
      s = mbx_pkg::SLV_PBUS0;
    end else if (a >= mbx_pkg::PBUS1_BASE && a <= mbx_pkg::PBUS1_END) begin
      s = mbx_pkg::SLV_PBUS1;
    end else if (a >= mbx_pkg::PBUS2_BASE && a <= mbx_pkg::PBUS2_END) begin
      s = mbx_pkg::SLV_PBUS2;
    end else if (a >= mbx_pkg::HS_BASE && a <= mbx_pkg::HS_END) begin
      s = mbx_pkg::SLV_HS_AHB;
    end else if (a >= mbx_pkg::PER_BB_BASE && a <= mbx_pkg::PER_BB_END) begin
      s = mbx_pkg::SLV_BB_ALIAS;
    end else if (a >= mbx_pkg::EXT_BASE && a <= mbx_pkg::EXT_END) begin
      s = mbx_pkg::SLV_EXT_BUS;
    end else if (a >= mbx_pkg::PPB_BASE && a <= mbx_pkg::PPB_END) begin
      s = mbx_pkg::SLV_PPB;
    end
    // a hole must not reach the bus behind it, so it reads as unmapped
    if (in_hole(a)) begin
      s = mbx_pkg::SLV_NONE;
    end
    return s;
  endfunction : decode

  // regions that the dma controller may not touch
  function automatic logic dma_blocked(input mbx_pkg::mbx_slv_t s);
    return (s == mbx_pkg::SLV_MAIN_FIF) || (s == mbx_pkg::SLV_PBUS0) ||
           (s == mbx_pkg::SLV_BB_ALIAS) || (s == mbx_pkg::SLV_PPB);
  endfunction : dma_blocked

  // page split inside the third peripheral bus
  function automatic logic [1:0] sub_region(input logic [31:0] a);
    logic [1:0] r;
    r = mbx_pkg::SUB_OTHER;
    if (a >= mbx_pkg::LVD_BASE && a <= mbx_pkg::LVD_END) begin
      r = mbx_pkg::SUB_LVD;
    end else if (a >= mbx_pkg::DSTBY_BASE && a <= mbx_pkg::DSTBY_END) begin
      r = mbx_pkg::SUB_DSTBY;
    end
    return r;
  endfunction : sub_region

  // little-endian lane strobe; narrow sizes refused only on the first peripheral bus
  function automatic logic [3:0] lane_strb(input logic [1:0] sz, input logic [1:0] a);
    logic [3:0] m;
    m = 4'hF;
    if (sz == mbx_pkg::SIZE_BYTE) begin
      m = 4'h1 << a;
    end else if (sz == mbx_pkg::SIZE_HALF) begin
      m = a[1] ? 4'hC : 4'h3;
    end
    return m;
  endfunction : lane_strb

  mbx_state_t state_reg;
  logic [2:0] owner_reg;
  logic [2:0] rr_last_reg;
  logic [31:0] rd_hold_reg;
  logic [31:0] flag_snap_reg;
  logic [2:0] pick;
  logic pick_valid;
  logic [31:0] req_addr;
  mbx_pkg::mbx_slv_t req_slv;
  logic req_bad;
  logic req_narrow_bad;
  localparam int NUM_MST_LOC = mbx_pkg::NUM_MST;

  // arbitration: fixed priority with dma first, or round-robin
  always_comb begin
    logic [2:0] idx;
    idx = 3'h0;
    pick = 3'h0;
    pick_valid = 1'b0;
    if (i_first_product_variant) begin
      if (i_m_req[mbx_pkg::M_DMA]) begin
        pick = mbx_pkg::M_DMA;
        pick_valid = 1'b1;
      end else begin
        for (int k = NUM_MST_LOC - 1; k >= 0; k--) begin
          if (i_m_req[k] && k != int'(mbx_pkg::M_DMA)) begin
            pick = 3'(k);
            pick_valid = 1'b1;
          end
        end
      end
    end else begin
      for (int k = NUM_MST_LOC; k >= 1; k--) begin
        idx = 3'((int'(rr_last_reg) + k) % NUM_MST_LOC);
        if (i_m_req[idx]) begin
          pick = idx;
          pick_valid = 1'b1;
        end
      end
    end
  end

  assign req_addr = i_m_addr[32*pick +: 32];
  assign req_slv = decode(req_addr);
  // narrow access to a bus without the extension is refused
  assign req_narrow_bad = (i_m_size[2*pick +: 2] != mbx_pkg::SIZE_WORD) &&
                          (req_slv == mbx_pkg::SLV_PBUS0);
  assign req_bad = (req_slv == mbx_pkg::SLV_NONE) || req_narrow_bad ||
                   ((pick == mbx_pkg::M_DMA) && dma_blocked(req_slv));

  // round-robin pointer: the next search starts past the last winner
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rr_last_reg <= 3'h4;
    end else if (i_ce && state_reg == ST_IDLE && pick_valid) begin
      rr_last_reg <= pick;
    end
  end

  // read data held for the owner; the locked write phase keeps the read value
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_hold_reg <= 32'h0000_0000;
      flag_snap_reg <= 32'h0000_0000;
    end else if (i_ce && state_reg == ST_ACCESS && i_s_ready) begin
      if (o_s_rmw && !o_s_write) begin
        // read phase: hardware flags read as one
        rd_hold_reg <= i_s_rdata | i_s_hw_flags;
        flag_snap_reg <= i_s_hw_flags;
      end else if (!o_s_rmw) begin
        rd_hold_reg <= i_s_rdata;
      end
    end
  end

  // transfer sequencer; the slave port is one layer, each master keeps its lane
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= ST_IDLE;
      owner_reg <= 3'h0;
      o_s_valid <= 1'b0;
      o_s_sel <= 4'h0;
      o_s_sub <= 2'h0;
      o_s_addr <= 32'h0000_0000;
      o_s_write <= 1'b0;
      o_s_strb <= 4'h0;
      o_s_wdata <= 32'h0000_0000;
      o_s_rmw <= 1'b0;
      o_s_lock <= 1'b0;
      o_s_master <= 3'h0;
      o_m_grant <= 5'h00;
      o_m_done <= 5'h00;
      o_m_err <= 5'h00;
    end else if (i_ce) begin
      o_m_done <= 5'h00;
      o_m_err <= 5'h00;
      unique case (state_reg)
        ST_IDLE: begin
          if (pick_valid) begin
            owner_reg <= pick;
            o_m_grant <= 5'h01 << pick;
            if (req_bad) begin
              // no slave sees the access; answer with error next cycle
              state_reg <= ST_DONE;
              o_m_err <= 5'h01 << pick;
            end else begin
              state_reg <= ST_ACCESS;
              o_s_valid <= 1'b1;
              o_s_sel <= req_slv;
              o_s_sub <= sub_region(req_addr);
              o_s_addr <= req_addr;
              o_s_master <= pick;
              o_s_strb <= lane_strb(i_m_size[2*pick +: 2], req_addr[1:0]);
              o_s_wdata <= i_m_wdata[32*pick +: 32];
              // bit-band on an extension bus runs read phase first, locked
              if (i_m_bitband[pick] && (req_slv == mbx_pkg::SLV_PBUS1 ||
                  req_slv == mbx_pkg::SLV_PBUS2)) begin
                o_s_rmw <= 1'b1;
                o_s_lock <= 1'b1;
                o_s_write <= 1'b0;
              end else begin
                o_s_rmw <= 1'b0; // plain access, flags unprotected
                o_s_lock <= 1'b0;
                o_s_write <= i_m_write[pick];
              end
            end
          end
        end
        ST_ACCESS: begin
          if (i_s_ready) begin
            if (o_s_rmw && !o_s_write) begin
              // read phase done: valid drops one cycle while write data is merged
              o_s_write <= 1'b1;
              state_reg <= ST_RMW_WR;
              o_s_valid <= 1'b0;
            end else begin
              o_s_valid <= 1'b0;
              o_s_lock <= 1'b0;
              o_s_rmw <= 1'b0;
              o_m_done <= 5'h01 << owner_reg;
              state_reg <= ST_DONE;
            end
          end
        end
        ST_RMW_WR: begin
          // write phase keeps every hardware flag set, late ones too
          o_s_valid <= 1'b1;
          o_s_wdata <= o_s_wdata | i_s_hw_flags | flag_snap_reg;
          state_reg <= ST_ACCESS;
        end
        ST_DONE: begin
          o_m_grant <= 5'h00;
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // read data back to the owning lane only
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_m_rdata <= 160'h0;
    end else if (i_ce && state_reg == ST_DONE) begin
      o_m_rdata[32*owner_reg +: 32] <= rd_hold_reg;
    end
  end

endmodule : mbx_matrix
`default_nettype wire

// ===== dv/mbx_matrix_properties.sv
// concurrent checks on the ports of the bus matrix
`timescale 1ns/1ps
`default_nettype none
module mbx_matrix_properties (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // master answer side
  input wire logic [4:0] o_m_grant,
  input wire logic [4:0] o_m_done,
  input wire logic [4:0] o_m_err,
  // slave side
  input wire logic o_s_valid,
  input wire logic [3:0] o_s_sel,
  input wire logic [31:0] o_s_addr,
  input wire logic o_s_write,
  input wire logic [3:0] o_s_strb,
  input wire logic [31:0] o_s_wdata,
  input wire logic o_s_rmw,
  input wire logic o_s_lock,
  input wire logic [2:0] o_s_master,
  input wire logic i_s_ready,
  input wire logic [31:0] i_s_hw_flags
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  one_grant_a: assert property ($onehot0(o_m_grant))
    else $error("more than one master granted");
  err_no_slave_a: assert property (|o_m_err |-> !o_s_valid)
    else $error("error answer with a slave access");
  done_after_ready_a: assert property (i_ce && o_s_valid && i_s_ready && (o_s_write || !o_s_rmw)
    |=> |o_m_done)
    else $error("no done after slave ready");
  hold_request_a: assert property (o_s_valid && !i_s_ready
    |=> o_s_valid && $stable(o_s_addr) && $stable(o_s_write))
    else $error("slave request changed before ready");
  rmw_locked_a: assert property (o_s_rmw |-> o_s_lock)
    else $error("rmw access without lock");
  rmw_read_first_a: assert property ($rose(o_s_rmw) |-> o_s_valid && !o_s_write)
    else $error("rmw does not open with a read");
  rmw_keep_flags_a: assert property (o_s_valid && o_s_rmw && o_s_write
    |-> (o_s_wdata & i_s_hw_flags) == i_s_hw_flags)
    else $error("rmw write clears a hardware flag");
  ext_window_a: assert property (o_s_valid && o_s_addr >= 32'h6000_0000
    && o_s_addr <= 32'hDFFF_FFFF |-> o_s_sel == mbx_pkg::SLV_EXT_BUS)
    else $error("external window misrouted");
  dma_barred_a: assert property (o_s_valid && o_s_master == mbx_pkg::M_DMA
    |-> o_s_sel != mbx_pkg::SLV_PBUS0 && o_s_sel != mbx_pkg::SLV_MAIN_FIF)
    else $error("dma reached a barred slave");
  lane_order_a: assert property (o_s_valid && $onehot(o_s_strb)
    |-> o_s_strb == (4'h1 << o_s_addr[1:0]))
    else $error("byte lane not little-endian");
  pbus0_word_a: assert property (o_s_valid && o_s_sel == mbx_pkg::SLV_PBUS0
    |-> o_s_strb == 4'hF)
    else $error("narrow access on first peripheral bus");
endmodule : mbx_matrix_properties
bind mbx_matrix mbx_matrix_properties u_mbx_matrix_properties (.i_sys_clk(i_sys_clk),
  .i_rst_n(i_rst_n), .i_ce(i_ce), .o_m_grant(o_m_grant), .o_m_done(o_m_done),
  .o_m_err(o_m_err), .o_s_valid(o_s_valid), .o_s_sel(o_s_sel), .o_s_addr(o_s_addr),
  .o_s_write(o_s_write), .o_s_strb(o_s_strb), .o_s_wdata(o_s_wdata), .o_s_rmw(o_s_rmw),
  .o_s_lock(o_s_lock), .o_s_master(o_s_master), .i_s_ready(i_s_ready),
  .i_s_hw_flags(i_s_hw_flags));
`default_nettype wire

// ===== dv/mbx_slave_model.sv
// slave partner: one storage word, wait states and hardware flags
`timescale 1ns/1ps
`default_nettype none
module mbx_slave_model (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // access from the matrix
  input wire logic i_s_valid,
  input wire logic i_s_write,
  input wire logic i_s_rmw,
  input wire logic [3:0] i_s_strb,
  input wire logic [31:0] i_s_wdata,
  // bench controls, changed only while idle
  input wire logic [1:0] i_wait,
  input wire logic [31:0] i_flag_pre,
  input wire logic [31:0] i_flag_mid,
  // answer
  output logic o_s_ready,
  output logic [31:0] o_s_rdata,
  output logic [31:0] o_hw_flags
);
  logic [1:0] wait_reg;
  logic [31:0] mem_reg;
  logic [31:0] mid_reg;
  // ready after the chosen wait; data scrambled outside a completing access
  assign o_s_ready = i_s_valid && (wait_reg == i_wait);
  assign o_s_rdata = o_s_ready ? mem_reg : ~mem_reg;
  assign o_hw_flags = i_flag_pre | mid_reg;
  // wait count restarts for every presented phase
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) wait_reg <= 2'h0;
    else if (!i_s_valid || o_s_ready) wait_reg <= 2'h0;
    else wait_reg <= wait_reg + 2'h1;
  end
  // hardware sets a flag just after the locked read completes
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) mid_reg <= 32'h0;
    else if (!i_s_rmw) mid_reg <= 32'h0;
    else if (o_s_ready && !i_s_write) mid_reg <= i_flag_mid;
  end
  // written lanes land little-endian, lane n holds byte address n
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) mem_reg <= 32'h0;
    else if (o_s_ready && i_s_write)
      for (int b = 0; b < 4; b++) if (i_s_strb[b]) mem_reg[8*b +: 8] <= i_s_wdata[8*b +: 8];
  end
endmodule : mbx_slave_model
`default_nettype wire

// ===== dv/multilayer_bus_matrix_decoder_tb_top.sv
// self-checking bench for the bus matrix decoder
`timescale 1ns/1ps
`default_nettype none
module multilayer_bus_matrix_decoder_tb_top;
  typedef struct packed {logic [2:0] m; logic [31:0] a; logic [1:0] sz; logic e;
    logic [3:0] sel; logic [1:0] sub; logic [3:0] st;} mbx_row_t;
  // only the error rows reach reserved space dma rows stay off bit-band alias
  localparam mbx_row_t ROWS [16] = '{
    '{3'h1, 32'h1FFF_FFFC, 2'h2, 1'b0, mbx_pkg::SLV_CODE_RAM, 2'h0, 4'hF},
    '{3'h3, 32'h2000_0000, 2'h2, 1'b0, mbx_pkg::SLV_SYS_RAM, 2'h0, 4'hF},
    '{3'h4, 32'h6000_0000, 2'h2, 1'b0, mbx_pkg::SLV_EXT_BUS, 2'h0, 4'hF},
    '{3'h2, 32'hDFFF_FFFC, 2'h2, 1'b0, mbx_pkg::SLV_EXT_BUS, 2'h0, 4'hF},
    '{3'h3, 32'h4000_0000, 2'h2, 1'b1, 4'h0, 2'h0, 4'h0},
    '{3'h3, 32'h4001_0000, 2'h2, 1'b1, 4'h0, 2'h0, 4'h0},
    '{3'h2, 32'h4001_0000, 2'h2, 1'b0, mbx_pkg::SLV_PBUS0, 2'h0, 4'hF},
    '{3'h2, 32'h4001_0002, 2'h1, 1'b1, 4'h0, 2'h0, 4'h0},
    '{3'h3, 32'h4002_E001, 2'h0, 1'b0, mbx_pkg::SLV_PBUS1, 2'h0, 4'h2},
    '{3'h3, 32'h4002_0002, 2'h1, 1'b0, mbx_pkg::SLV_PBUS1, 2'h0, 4'hC},
    '{3'h4, 32'h4003_5003, 2'h0, 1'b0, mbx_pkg::SLV_PBUS2, 2'h1, 4'h8},
    '{3'h4, 32'h4003_5100, 2'h2, 1'b0, mbx_pkg::SLV_PBUS2, 2'h2, 4'hF},
    '{3'h3, 32'h200E_0000, 2'h2, 1'b0, mbx_pkg::SLV_WORK_FIF, 2'h0, 4'hF},
    '{3'h2, 32'h4001_3000, 2'h2, 1'b1, 4'h0, 2'h0, 4'h0},
    '{3'h4, 32'h4002_9000, 2'h2, 1'b1, 4'h0, 2'h0, 4'h0},
    '{3'h3, 32'hE000_0000, 2'h2, 1'b1, 4'h0, 2'h0, 4'h0}};
  logic i_sys_clk = 1'b0, i_rst_n = 1'b0, i_first_product_variant = 1'b1, i_ce = 1'b1;
  logic [4:0] i_m_req = '0, i_m_write = '0, i_m_bitband = '0, o_m_grant, o_m_done, o_m_err;
  logic [159:0] i_m_addr = '0, i_m_wdata = '0, o_m_rdata;
  logic [9:0] i_m_size = '0;
  logic o_s_valid, o_s_write, o_s_rmw, o_s_lock, i_s_ready;
  logic [3:0] o_s_sel, o_s_strb;
  logic [1:0] o_s_sub, slv_wait = 2'h0;
  logic [2:0] o_s_master;
  logic [31:0] o_s_addr, o_s_wdata, i_s_rdata, i_s_hw_flags, flag_pre = '0, flag_mid = '0;
  int err_total = 0, n_compared = 0;
  logic e;
  logic [3:0] sel, st;
  logic [1:0] sub;
  logic [31:0] rd;
  // clock enable stays high except in the freeze test at the end
  mbx_matrix u_mbx_matrix (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
    .i_first_product_variant(i_first_product_variant), .i_m_req(i_m_req),
    .i_m_write(i_m_write), .i_m_bitband(i_m_bitband), .i_m_addr(i_m_addr),
    .i_m_size(i_m_size), .i_m_wdata(i_m_wdata), .o_m_grant(o_m_grant), .o_m_done(o_m_done),
    .o_m_err(o_m_err), .o_m_rdata(o_m_rdata), .o_s_valid(o_s_valid), .o_s_sel(o_s_sel),
    .o_s_sub(o_s_sub), .o_s_addr(o_s_addr), .o_s_write(o_s_write), .o_s_strb(o_s_strb),
    .o_s_wdata(o_s_wdata), .o_s_rmw(o_s_rmw), .o_s_lock(o_s_lock), .o_s_master(o_s_master),
    .i_s_ready(i_s_ready), .i_s_rdata(i_s_rdata), .i_s_hw_flags(i_s_hw_flags));
  mbx_slave_model u_mbx_slave_model (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_s_valid(o_s_valid), .i_s_write(o_s_write), .i_s_rmw(o_s_rmw), .i_s_strb(o_s_strb),
    .i_s_wdata(o_s_wdata), .i_wait(slv_wait), .i_flag_pre(flag_pre), .i_flag_mid(flag_mid),
    .o_s_ready(i_s_ready), .o_s_rdata(i_s_rdata), .o_hw_flags(i_s_hw_flags));
  always #4 i_sys_clk = ~i_sys_clk;
  task automatic test_done;
    $display("mismatches %0d of %0d compared", err_total, n_compared);
    if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  // one access, held until done or error; slave view captured at its first cycle
  task automatic acc(input int m, input logic [31:0] a, input logic [1:0] sz,
      input logic bb, input logic wr, input logic [31:0] wd);
    int k;
    logic seen;
    seen = 1'b0;
    sel = '0; sub = '0; st = '0;
    @(posedge i_sys_clk);
    i_m_req[m] <= 1'b1; i_m_addr[32*m +: 32] <= a; i_m_size[2*m +: 2] <= sz;
    i_m_bitband[m] <= bb; i_m_write[m] <= wr; i_m_wdata[32*m +: 32] <= wd;
    for (k = 0; k < 60; k++) begin
      @(posedge i_sys_clk);
      #1;
      if (o_s_valid === 1'b1 && !seen) begin
        seen = 1'b1; sel = o_s_sel; sub = o_s_sub; st = o_s_strb;
      end
      if (o_m_done[m] === 1'b1 || o_m_err[m] === 1'b1) break;
    end
    if (k == 60) begin
      err_total++;
      $display("mismatch at %0t: access never answered", $time);
      test_done();
    end
    e = o_m_err[m];
    @(posedge i_sys_clk);
    i_m_req[m] <= 1'b0;
    #1 rd = o_m_rdata[32*m +: 32];
  endtask : acc
  // dcode and dma both keep requesting; the order of completions shows the arbiter
  task automatic arb(input logic fv);
    int k, n;
    logic [2:0] cur, prev;
    n = 0; prev = 3'h0;
    @(posedge i_sys_clk);
    i_first_product_variant <= fv; i_m_write <= '0; i_m_bitband <= '0; i_m_size <= {5{2'h2}};
    i_m_addr[32 +: 32] <= 32'h2000_0000; i_m_addr[96 +: 32] <= 32'h2000_0004;
    @(posedge i_sys_clk);
    i_m_req <= 5'h0A;
    for (k = 0; k < 300 && n < 4; k++) begin
      @(posedge i_sys_clk);
      #1;
      if (o_m_done[3] === 1'b1 || o_m_done[1] === 1'b1) begin
        cur = o_m_done[3] ? 3'h3 : 3'h1;
        if (fv) chk(cur, mbx_pkg::M_DMA, "fixed winner");
        else if (n > 0) chk(cur, (prev == 3'h1) ? 3'h3 : 3'h1, "rotating winner");
        prev = cur; n++;
      end
    end
    @(posedge i_sys_clk);
    i_m_req <= 5'h0;
    if (n < 4) begin
      err_total++;
      $display("mismatch at %0t: arbitration stalled", $time);
      test_done();
    end
  endtask : arb
  initial begin
    repeat (5) @(posedge i_sys_clk);
    chk(o_s_valid, 1'b0, "slave request in reset");
    i_rst_n <= 1'b1;
    // decode table, slave wait varied per row
    for (int i = 0; i < 16; i++) begin
      slv_wait <= 2'(i % 3);
      acc(ROWS[i].m, ROWS[i].a, ROWS[i].sz, 1'b0, 1'b1, 32'hA5A5_5A5A);
      chk(e, ROWS[i].e, "error answer");
      chk(sel, ROWS[i].sel, "slave select");
      chk(st, ROWS[i].st, "byte strobes");
      if (ROWS[i].sel == mbx_pkg::SLV_PBUS2) chk(sub, ROWS[i].sub, "page part");
    end
    // locked rmw keeps the flag seen at read and the one set just after it
    acc(2, 32'h4003_0000, 2'h2, 1'b0, 1'b1, 32'h0);
    flag_pre <= 32'h0000_0001; flag_mid <= 32'h0000_0100;
    acc(2, 32'h4003_0000, 2'h2, 1'b1, 1'b1, 32'h0000_0010);
    chk(e, 1'b0, "rmw answer");
    chk(rd, 32'h0000_0001, "rmw read flag");
    acc(2, 32'h4003_0000, 2'h2, 1'b0, 1'b0, 32'h0);
    chk(rd, 32'h0000_0111, "rmw result");
    // a plain write gets no protection: set flags are overwritten
    acc(2, 32'h4003_0000, 2'h2, 1'b0, 1'b1, 32'h0);
    acc(2, 32'h4003_0000, 2'h2, 1'b0, 1'b0, 32'h0);
    chk(rd, 32'h0, "plain write result");
    arb(1'b1);
    arb(1'b0);
    // a low clock enable freezes the matrix: a waiting request stays ungranted
    @(posedge i_sys_clk);
    i_ce <= 1'b0;
    i_m_req[0] <= 1'b1;
    i_m_addr[31:0] <= 32'h2000_0008;
    repeat (3) @(posedge i_sys_clk);
    #1 chk(o_m_grant, 5'h00, "grant while frozen");
    @(posedge i_sys_clk);
    i_ce <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    #1 chk(o_m_grant, 5'h01, "grant after thaw");
    @(posedge i_sys_clk);
    i_m_req[0] <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    test_done();
  end
endmodule : multilayer_bus_matrix_decoder_tb_top
`default_nettype wire
